// File: logic/serdes_line_status.sv
// receive clocking, system clock and line status outputs of the serdes parallel side
//
// Behaviour
// - Write mode: drive receive clock pin with the recovered word clock.
// - Read mode: pin is input; launch received word on both its edges.
// - Produce 30.72 MHz system clock only while operating select is low.
// - Signal-lost flag reports loss in 8-bit mode only, else stays low.
// - Active-low unlocked output is 0 when PLL locked, 1 otherwise.
// - Comma seen stays 0 before any comma or while PLL unlocked.
// - Comma seen rises only with PLL locked and a comma detected.
// - With comma alignment enabled, word boundary follows the detected comma.
// - In 8-bit mode, top word bit flags a code violation for one word.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "serdes_map.svh"

module serdes_line_status (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        rx_serial_bit,
    input  wire logic        rx_serial_valid,
    input  wire logic        signal_detect,
    input  wire logic        rx_pll_locked,
    input  wire logic        operating_select,
    input  wire logic        rx_clock_direction_select,
    input  wire logic        rx_parallel_clock_in,
    output logic             rx_parallel_clock_out,
    output logic             rx_parallel_clock_oe,
    output logic [9:0]       rx_parallel_word,
    output logic             system_clock_out_p,
    output logic             system_clock_out_n,
    output logic             signal_lost_flag,
    output logic             rx_pll_unlocked_n,
    output logic             comma_seen,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic             irq
);

    logic [1:0]             rst_sync;
    logic                   rst_n;
    serdes_pkg::line_s      st;
    serdes_pkg::line_s      next_st;
    logic [9:0]             al_word;
    logic                   al_valid;
    logic                   al_comma;
    logic [`PIN_COUNT-1:0]  pins;
    logic                   locked;
    logic                   read_mode;
    logic                   ext_edge;
    logic                   word_lcv;
    logic [16:0]            nco_sum;
    logic [3:0]             events;
    logic                   status_read;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // register decode, shared by read and write paths
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // invalid 10-bit code: disparity outside -2..+2 cannot be a legal code group
    function automatic logic code_invalid(input logic [9:0] w);
        logic [3:0] ones;
        ones = 4'h0;
        for (int i = 0; i < 10; i++) begin
            ones = ones + {3'h0, w[i]};
        end
        code_invalid = (ones < 4'h4) || (ones > 4'h6);
    endfunction

    // parallel word layout: raw code group, or byte with K indicator and violation bit
    function automatic logic [9:0] word_format(input logic [9:0] w, input logic lcv,
                                               input logic eight_bit);
        logic is_k;
        is_k = (w[5:0] == `K28_POS) || (w[5:0] == `K28_NEG);
        word_format = eight_bit ? {lcv, is_k, w[7:0]} : w;
    endfunction

    word_aligner u_aligner (
        .clk          (clk),
        .rst_n        (rst_n),
        .bit_in       (rx_serial_bit),
        .bit_valid    (rx_serial_valid),
        .align_enable (st.ctrl.align_en),
        .word         (al_word),
        .word_valid   (al_valid),
        .comma_hit    (al_comma)
    );

    assign pins = {rx_clock_direction_select, operating_select, rx_pll_locked,
                   signal_detect, rx_parallel_clock_in};

    // whole next state of the block
    always_comb begin
        next_st     = st;
        word_lcv    = code_invalid(al_word);
        nco_sum     = 17'h0;
        status_read = reg_read && reg_hit(reg_addr, `REG_IRQ_STATUS);

        // pin synchronisers: s1 only feeds s2, a level counts once s2 and s3 agree
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < `PIN_COUNT; i++) begin
            next_st.stable[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.stable[i];
        end
        locked    = next_st.stable[`PIN_LOCKED];
        read_mode = st.stable[`PIN_DIRSEL];
        ext_edge  = st.stable[`PIN_RX_PARALLEL_CLOCK] != st.ext_prev;
        next_st.ext_prev = st.stable[`PIN_RX_PARALLEL_CLOCK];

        next_st.unlocked_n = !locked;
        next_st.seen = locked && (st.seen || al_comma);
        next_st.lost_flag = st.ctrl.eight_bit && !st.stable[`PIN_DETECT];

        // phase accumulator, parked low while operating select is high
        if (st.stable[`PIN_OPSEL]) begin
            next_st.nco     = 16'h0;
            next_st.sys_clk = 1'b0;
        end else begin
            nco_sum     = {1'b0, st.nco} + {1'b0, 16'(`NCO_STEP)};
            next_st.nco = nco_sum[15:0];
            if (nco_sum[16]) begin
                next_st.sys_clk = !st.sys_clk;
            end
        end

        // every aligned word is held for the read-mode launch
        if (al_valid) begin
            next_st.hold     = al_word;
            next_st.hold_lcv = word_lcv;
        end

        // write mode: word clock toggles with each launched word
        if (!read_mode && al_valid) begin
            next_st.rec_clk = !st.rec_clk;
            next_st.word = word_format(al_word, word_lcv, st.ctrl.eight_bit);
        end
        // read mode: launch on both partner clock edges
        if (read_mode && ext_edge) begin
            next_st.word = word_format(st.hold, st.hold_lcv, st.ctrl.eight_bit);
        end

        // sticky events; a new event wins over the clearing read
        events = 4'h0;
        events[`IRQ_COMMA]       = next_st.seen && !st.seen;
        events[`IRQ_LOCK_LOST]   = st.stable[`PIN_LOCKED] && !locked;
        events[`IRQ_SIGNAL_LOST] = next_st.lost_flag && !st.lost_flag;
        events[`IRQ_CODE_VIOL]   = al_valid && st.ctrl.eight_bit && word_lcv;
        next_st.irq_status = (st.irq_status & ~(status_read ? 4'hF : 4'h0)) | events;

        // register writes
        if (reg_write && reg_hit(reg_addr, `REG_CONTROL)) begin
            next_st.ctrl.align_en  = reg_wdata[`CTL_ALIGN_BIT];
            next_st.ctrl.eight_bit = reg_wdata[`CTL_EIGHT_BIT];
        end
        if (reg_write && reg_hit(reg_addr, `REG_IRQ_MASK)) begin
            next_st.irq_mask = reg_wdata[3:0];
        end

        // read data stand one cycle only; unmapped offsets read zero
        next_st.rdata = 32'h0;
        if (reg_read) begin
            if (reg_hit(reg_addr, `REG_CONTROL)) begin
                next_st.rdata[1:0] = {st.ctrl.eight_bit, st.ctrl.align_en};
            end else if (reg_hit(reg_addr, `REG_LINE_STATUS)) begin
                next_st.rdata[4:0] = {st.stable[`PIN_OPSEL], read_mode, st.seen,
                                      st.unlocked_n, st.lost_flag};
            end else if (reg_hit(reg_addr, `REG_IRQ_STATUS)) begin
                next_st.rdata[3:0] = st.irq_status;
            end else if (reg_hit(reg_addr, `REG_IRQ_MASK)) begin
                next_st.rdata[3:0] = st.irq_mask;
            end
        end
    end

    // state register; unlocked output starts high since nothing is locked yet
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st            <= '0;
            st.unlocked_n <= 1'b1;
            st.ctrl       <= `CTL_RESET;
            st.irq_status <= `IRQ_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign rx_parallel_clock_out = st.rec_clk;
    assign rx_parallel_clock_oe  = !st.stable[`PIN_DIRSEL];
    assign rx_parallel_word      = st.word;
    assign system_clock_out_p    = st.sys_clk;
    assign system_clock_out_n    = !st.sys_clk;
    assign signal_lost_flag      = st.lost_flag;
    assign rx_pll_unlocked_n     = st.unlocked_n;
    assign comma_seen            = st.seen;
    assign reg_rdata             = st.rdata;
    assign irq                   = |(st.irq_status & st.irq_mask);

    sequence lock_held_high;
        rx_pll_locked [*6];
    endsequence

    sequence lock_held_low;
        !rx_pll_locked [*6];
    endsequence

    a_lock_shown: assert property (@(posedge clk) disable iff (!rst_n)
        lock_held_high |-> !rx_pll_unlocked_n)
        else $error("unlocked output high while lock held");

    a_unlock_shown: assert property (@(posedge clk) disable iff (!rst_n)
        lock_held_low |-> rx_pll_unlocked_n)
        else $error("unlocked output low while lock absent");

    a_comma_needs_lock: assert property (@(posedge clk) disable iff (!rst_n)
        rx_pll_unlocked_n |-> !comma_seen)
        else $error("comma seen while unlocked");

    a_comma_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(comma_seen) |-> $past(al_comma) && !rx_pll_unlocked_n)
        else $error("comma seen rose without a comma");

    a_los_mode: assert property (@(posedge clk) disable iff (!rst_n)
        !st.ctrl.eight_bit |=> !signal_lost_flag)
        else $error("loss flag outside 8-bit mode");

    a_sysclk_gate: assert property (@(posedge clk) disable iff (!rst_n)
        operating_select [*6] |-> !system_clock_out_p && system_clock_out_n)
        else $error("system clock running with select high");

    a_sysclk_runs: assert property (@(posedge clk) disable iff (!rst_n)
        !operating_select [*6] |-> ##[1:2] $changed(system_clock_out_p))
        else $error("system clock stalled with select low");

    a_rx_parallel_clock_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (!read_mode && al_valid) |=> rx_parallel_clock_oe && $changed(rx_parallel_clock_out))
        else $error("recovered clock not driven with a word");

    a_read_launch: assert property (@(posedge clk) disable iff (!rst_n)
        (read_mode && ext_edge) |=> rx_parallel_word[7:0] == $past(st.hold[7:0]))
        else $error("word not launched on partner clock edge");

    a_lcv_bit: assert property (@(posedge clk) disable iff (!rst_n)
        (read_mode && ext_edge && st.ctrl.eight_bit) |=> rx_parallel_word[9] == $past(st.hold_lcv))
        else $error("violation bit does not match launched word");

    a_pin_driven: assert property (@(posedge clk) disable iff (!rst_n)
        !rx_clock_direction_select [*6] |-> rx_parallel_clock_oe)
        else $error("receive clock pin not driven in write mode");

    a_pin_released: assert property (@(posedge clk) disable iff (!rst_n)
        rx_clock_direction_select [*6] |-> !rx_parallel_clock_oe)
        else $error("receive clock pin driven in read mode");

    a_rx_parallel_clock_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        read_mode |=> $stable(rx_parallel_clock_out))
        else $error("recovered clock toggled in read mode");

    a_write_word: assert property (@(posedge clk) disable iff (!rst_n)
        (!read_mode && al_valid && !st.ctrl.eight_bit) |=> rx_parallel_word == $past(al_word))
        else $error("write mode word differs from aligned word");

    a_read_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (read_mode && !ext_edge) |=> $stable(rx_parallel_word))
        else $error("word changed without a partner clock edge");

    a_los_shown: assert property (@(posedge clk) disable iff (!rst_n)
        (st.ctrl.eight_bit && !signal_detect) [*6] |-> signal_lost_flag)
        else $error("loss flag low while signal absent");

    a_los_clear: assert property (@(posedge clk) disable iff (!rst_n)
        signal_detect [*6] |-> !signal_lost_flag)
        else $error("loss flag high while signal present");

    a_comma_drop: assert property (@(posedge clk) disable iff (!rst_n)
        !rx_pll_locked [*6] |-> !comma_seen)
        else $error("comma seen held without lock");

    a_comma_rise: assert property (@(posedge clk) disable iff (!rst_n)
        (al_comma && locked) |=> comma_seen)
        else $error("comma while locked not reported");

    a_lcv_write: assert property (@(posedge clk) disable iff (!rst_n)
        (!read_mode && al_valid && st.ctrl.eight_bit) |=> rx_parallel_word[9] == $past(word_lcv))
        else $error("violation bit wrong in write mode");

endmodule // serdes_line_status

// File: logic/serdes_map.svh
// register offsets, field positions, reset values and timing counts of the line status block
`ifndef SERDES_MAP_SVH
`define SERDES_MAP_SVH

// register byte offsets
`define REG_CONTROL      4'h0
`define REG_LINE_STATUS  4'h4
`define REG_IRQ_STATUS   4'h8
`define REG_IRQ_MASK     4'hC

// control register fields
`define CTL_ALIGN_BIT    0
`define CTL_EIGHT_BIT    1
`define CTL_RESET        2'h0

// interrupt status fields
`define IRQ_COMMA        0
`define IRQ_LOCK_LOST    1
`define IRQ_SIGNAL_LOST  2
`define IRQ_CODE_VIOL    3
`define IRQ_RESET        4'h0

// synchronised pin indices
`define PIN_RX_PARALLEL_CLOCK        0
`define PIN_DETECT       1
`define PIN_LOCKED       2
`define PIN_OPSEL        3
`define PIN_DIRSEL       4
`define PIN_COUNT        5

// comma patterns, first received bit in bit 0
`define COMMA_POS        7'h7C
`define COMMA_NEG        7'h03
`define K28_POS          6'h3C
`define K28_NEG          6'h03
`define WORD_LAST_BIT    4'h9

// system clock synthesis: frequencies in kHz, step of a 16-bit phase accumulator
`define SYSCLK_KHZ       30720
`define CLK_KHZ          100000
`define NCO_STEP         (64'd2 * 64'd`SYSCLK_KHZ * 64'd65536 / 64'd`CLK_KHZ)

`endif

// File: logic/serdes_pkg.sv
// types shared by the line status block and its word aligner
package serdes_pkg;

    typedef struct packed {
        logic eight_bit;
        logic align_en;
    } ctrl_s;

    typedef struct packed {
        logic [9:0] shift;
        logic [3:0] count;
        logic [9:0] word;
        logic       word_valid;
        logic       comma_hit;
    } aligner_s;

    typedef struct packed {
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic [4:0]  s3;
        logic [4:0]  stable;
        logic        ext_prev;
        ctrl_s       ctrl;
        logic [3:0]  irq_status;
        logic [3:0]  irq_mask;
        logic [31:0] rdata;
        logic [15:0] nco;
        logic        sys_clk;
        logic        rec_clk;
        logic [9:0]  hold;
        logic        hold_lcv;
        logic [9:0]  word;
        logic        lost_flag;
        logic        seen;
        logic        unlocked_n;
    } line_s;

endpackage

// File: logic/word_aligner.sv
// serial-to-parallel converter with comma search and word boundary alignment
`timescale 1ns/1ps
`include "serdes_map.svh"

module word_aligner (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       bit_in,
    input  wire logic       bit_valid,
    input  wire logic       align_enable,
    output logic [9:0]      word,
    output logic            word_valid,
    output logic            comma_hit
);

    serdes_pkg::aligner_s st;
    serdes_pkg::aligner_s next_st;
    logic                 comma_now;

    // shift in one bit, look for a comma in the first seven bits of the window
    always_comb begin
        next_st            = st;
        next_st.word_valid = 1'b0;
        next_st.comma_hit  = 1'b0;
        comma_now          = 1'b0;
        if (bit_valid) begin
            next_st.shift = {bit_in, st.shift[9:1]};
            comma_now     = (next_st.shift[6:0] == `COMMA_POS) ||
                            (next_st.shift[6:0] == `COMMA_NEG);
            next_st.comma_hit = comma_now;
            if ((align_enable && comma_now) || st.count == `WORD_LAST_BIT) begin
                next_st.word       = next_st.shift;
                next_st.word_valid = 1'b1;
                next_st.count      = 4'h0;
            end else begin
                next_st.count = st.count + 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign word       = st.word;
    assign word_valid = st.word_valid;
    assign comma_hit  = st.comma_hit;

    sequence comma_in_window;
        bit_valid && align_enable && comma_now;
    endsequence

    sequence word_restarts;
        word_valid && st.count == 4'h0;
    endsequence

    a_align_boundary: assert property (@(posedge clk) disable iff (!rst_n)
        comma_in_window |=> word_restarts)
        else $error("aligned comma did not start a word");

    a_word_period: assert property (@(posedge clk) disable iff (!rst_n)
        (bit_valid && !align_enable && st.count != `WORD_LAST_BIT) |=> !word_valid)
        else $error("word emitted before ten bits without alignment");

endmodule // word_aligner

// File: test/framer_model.sv
// framing-side partner: supplies the read-mode receive clock and the transmit clock
`timescale 1ns/1ps

module framer_model (
    input  wire logic clk,
    input  wire logic run,
    output logic      rx_clock,
    output logic      tx_clock
);
    logic [1:0] div;

    // locked read clock
    // derived from the same clock as the serial bits, so it can never drift;
    // stands still while not running, as between frames
    always @(posedge clk) begin
        div <= div + 2'h1;
        if (run && div == 2'h3) begin
            rx_clock <= ~rx_clock;
        end
    end

    always @(posedge clk) begin
        tx_clock <= ~tx_clock;
    end

    initial begin
        div = 2'h0;
        rx_clock = 1'b0;
        tx_clock = 1'b0;
    end
endmodule // framer_model

// File: test/test_serdes_line_status.sv
// self-checking bench of the line status block
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end

module test_serdes_line_status;
    logic        clk, arst_n, sbit, svalid, detect, locked, opsel, dirsel, run;
    logic        pclk_in, pclk_out, pclk_oe, sys_p, sys_n, lost, unl_n, seen, irq;
    logic [9:0]  word;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic        reg_write, reg_read, old;
    int          mismatches, cmp_count, cyc, i, n;
    // row: detect, locked, eight_bit, expected unlocked_n, expected lost
    logic [4:0]  rows [4] = '{5'b11000, 5'b01000, 5'b00111, 5'b10110};

    serdes_line_status uut (.clk(clk), .arst_n(arst_n), .rx_serial_bit(sbit),
        .rx_serial_valid(svalid), .signal_detect(detect), .rx_pll_locked(locked),
        .operating_select(opsel), .rx_clock_direction_select(dirsel),
        .rx_parallel_clock_in(pclk_in), .rx_parallel_clock_out(pclk_out),
        .rx_parallel_clock_oe(pclk_oe), .rx_parallel_word(word),
        .system_clock_out_p(sys_p), .system_clock_out_n(sys_n),
        .signal_lost_flag(lost), .rx_pll_unlocked_n(unl_n), .comma_seen(seen),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

    framer_model partner (.clk(clk), .run(run), .rx_clock(pclk_in), .tx_clock());

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // serial bits go out first bit lowest
    task automatic send(input logic [9:0] w, input int nb);
        for (int k = 0; k < nb; k++) begin
            @(posedge clk);
            sbit   <= w[k];
            svalid <= 1'b1;
        end
        @(posedge clk);
        svalid <= 1'b0;
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    initial begin
        {arst_n, sbit, svalid, detect, locked, dirsel, run, reg_write, reg_read} = '0;
        opsel = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        wait_cyc(5);
        arst_n = 1'b1;
        wait_cyc(4);
        `CHK("unlocked_n", 1'b1, unl_n) // reset unlocked
        `CHK("seen", 1'b0, seen) // no comma yet
        // status pins against expected outputs, system clock parked
        for (i = 0; i < 4; i++) begin
            wr(4'h0, {30'h0, rows[i][2], 1'b0});
            detect <= rows[i][4];
            locked <= rows[i][3];
            wait_cyc(8);
            `CHK("unlocked_n", rows[i][1], unl_n) // lock output
            `CHK("lost", rows[i][0], lost) // lost in 8-bit only
            `CHK("seen", 1'b0, seen) // nothing seen
            `CHK("sys", 2'b01, {sys_p, sys_n}) // parked while select high
        end
        // clock runs: 30.72 MHz over 1000 cycles gives 307 rising edges
        opsel <= 1'b0;
        wait_cyc(10);
        n = 0;
        for (i = 0; i < 1000; i++) begin
            old = sys_p;
            wait_cyc(1);
            if (!old && sys_p) n++;
        end
        `CHK("sys_rate", 1'b1, n >= 306 && n <= 308) // system clock rate
        `CHK("sys_pair", 1'b1, sys_p !== sys_n) // differential pair
        // comma after junk bits, alignment on, lock present
        wr(4'h0, 32'h1);
        wr(4'hC, 32'h1);
        rd(4'h8, d);
        locked <= 1'b1;
        detect <= 1'b1;
        wait_cyc(8);
        send(10'h005, 3);
        send(10'h17C, 10);
        wait_cyc(3);
        `CHK("word", 10'h17C, word) // aligned to comma
        `CHK("seen", 1'b1, seen) // comma while locked
        `CHK("oe", 1'b1, pclk_oe) // pin driven in write mode
        `CHK("irq", 1'b1, irq)
        old = pclk_out;
        send(10'h17C, 10);
        wait_cyc(3);
        `CHK("rec_clk", ~old, pclk_out) // recovered clock per word
        rd(4'h8, d);
        `CHK("irq_stat", 1'b1, d[0])
        rd(4'h8, d);
        `CHK("irq_clear", 32'h0, d)
        `CHK("irq", 1'b0, irq)
        rd(4'h1, d);
        `CHK("unmapped", 32'h0, d)
        // code violation flag in 8-bit mode, then a clean word
        wr(4'h0, 32'h3);
        send(10'h3FF, 10);
        wait_cyc(3);
        `CHK("viol", 1'b1, word[9]) // violation flagged
        send(10'h17C, 10);
        wait_cyc(3);
        `CHK("viol", 1'b0, word[9]) // one word only
        // losing lock drops comma indication
        locked <= 1'b0;
        wait_cyc(8);
        `CHK("seen", 1'b0, seen) // unlocked clears
        `CHK("unlocked_n", 1'b1, unl_n) // not locked
        // read mode: partner clock, held word relaunched on each edge
        d = {22'h0, word};
        dirsel <= 1'b1;
        run <= 1'b1;
        wait_cyc(8);
        `CHK("oe", 1'b0, pclk_oe) // pin is an input
        wait_cyc(40);
        `CHK("word", d[9:0], word) // relaunch of held word
        tally_and_finish();
    end
endmodule // test_serdes_line_status
